// file: include/dma_event_pkg.sv
/*
  Constants and carrier types for the DMA channel event and interrupt routing logic.
  Assumes a single core clock; all event inputs are single-cycle pulses on that clock.
*/
// Operation
// - A channel raises no interrupt while its interrupt enable bit is 0.
// - Autobuffer mode interrupts at full buffer, and also at half buffer when half mode is 1.
// - Multi-frame mode with half mode 0 interrupts only when element and frame counts are zero.
// - Multi-frame mode with half mode 1 interrupts at every frame end and at block end.
// - Each channel has a 4-bit sync select where 0000b means run unsynchronized.
// - Sync codes 0001b-0110b select port 0, port 2, then port 1 receive and transmit events.
// - Code 1101b selects the timer event, 1110b external interrupt 3; the rest are reserved.
// - Each of the six channels has its own interrupt request.
// - Channels 0-3 share CPU interrupt lines with port interrupts under a 2-bit routing select.
// - Routing 00b, the reset value, puts port 2 on lines 6/7 and port 1 on lines 10/11.
// - Routing 01b keeps port 2 on lines 6/7 and puts channels 2 and 3 on lines 10/11.
// - Routing 10b puts channels 0 to 3 on lines 6, 7, 10 and 11; 11b is reserved.
// - Frame count drops on a frame's last read, element count on each read; both end at zero.
package dma_event_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NUM_CHANNELS  = 6;
  localparam int ELEM_WIDTH    = 16;
  localparam int FRAME_WIDTH   = 8;
  localparam int SYNC_WIDTH    = 4;
  localparam int ROUTE_WIDTH   = 2;

  // ----------------------------------------------------------------------
  // Sync select codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] SYNC_NONE     = 4'h0;
  localparam logic [3:0] SYNC_P0_RX    = 4'h1;
  localparam logic [3:0] SYNC_P0_TX    = 4'h2;
  localparam logic [3:0] SYNC_P2_RX    = 4'h3;
  localparam logic [3:0] SYNC_P2_TX    = 4'h4;
  localparam logic [3:0] SYNC_P1_RX    = 4'h5;
  localparam logic [3:0] SYNC_P1_TX    = 4'h6;
  localparam logic [3:0] SYNC_TIMER    = 4'hd;
  localparam logic [3:0] SYNC_EXT3     = 4'he;

  // ----------------------------------------------------------------------
  // Routing select codes and CPU line positions
  // ----------------------------------------------------------------------
  localparam logic [1:0] ROUTE_PORTS   = 2'h0;
  localparam logic [1:0] ROUTE_HALF    = 2'h1;
  localparam logic [1:0] ROUTE_DMA     = 2'h2;
  localparam logic [1:0] ROUTE_RESET   = 2'h0;
  localparam int CPU_IRQ_WIDTH = 16;
  localparam int LINE_A        = 6;
  localparam int LINE_B        = 7;
  localparam int LINE_C        = 10;
  localparam int LINE_D        = 11;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       channelInterruptEnable;
    logic       halfInterruptMode;
    logic       autobufferMode;
    logic [3:0] syncEventSelect;
  } chan_cfg_type;

  typedef struct packed {
    logic p0Rx;
    logic p0Tx;
    logic p2Rx;
    logic p2Tx;
    logic p1Rx;
    logic p1Tx;
    logic timer;
    logic ext3;
  } sync_src_type;

  typedef struct packed {
    logic port2ReceiveIrq;
    logic port2TransmitIrq;
    logic port1ReceiveIrq;
    logic port1TransmitIrq;
  } port_irq_type;

  typedef struct packed {
    logic                  elemRead;
    logic                  halfBuffer;
    logic [ELEM_WIDTH-1:0] elementCounter;
    logic [FRAME_WIDTH-1:0] frameCount;
  } xfer_status_type;

endpackage : dma_event_pkg

// file: rtl/dma_channel_event.sv
/*
  One channel: sync event selection and channel interrupt generation.
  Assumes counter values are sampled with the element read pulse after decrement.
*/
`timescale 1ns/100ps
module dma_channel_event (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  // Configuration and events
  input  wire dma_event_pkg::chan_cfg_type    cfg,
  input  wire dma_event_pkg::sync_src_type    syncSrc,
  input  wire dma_event_pkg::xfer_status_type status,
  // Results
  output logic                               syncEvent,
  output logic                               channelIrq
);

  // ----------------------------------------------------------------------
  // Sync event selection
  // ----------------------------------------------------------------------
  logic nxt_sync;
  logic syncEvent_ff;

  always_comb begin
    case (cfg.syncEventSelect)
      dma_event_pkg::SYNC_NONE:  nxt_sync = 1'b1;
      dma_event_pkg::SYNC_P0_RX: nxt_sync = syncSrc.p0Rx;
      dma_event_pkg::SYNC_P0_TX: nxt_sync = syncSrc.p0Tx;
      dma_event_pkg::SYNC_P2_RX: nxt_sync = syncSrc.p2Rx;
      dma_event_pkg::SYNC_P2_TX: nxt_sync = syncSrc.p2Tx;
      dma_event_pkg::SYNC_P1_RX: nxt_sync = syncSrc.p1Rx;
      dma_event_pkg::SYNC_P1_TX: nxt_sync = syncSrc.p1Tx;
      dma_event_pkg::SYNC_TIMER: nxt_sync = syncSrc.timer;
      dma_event_pkg::SYNC_EXT3:  nxt_sync = syncSrc.ext3;
      default:                   nxt_sync = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Interrupt generation
  // ----------------------------------------------------------------------
  logic lastElem;
  logic blockEnd;
  logic nxt_irq;
  logic channelIrq_ff;

  always_comb begin
    // Counters reach zero on the read that finishes the frame or block
    lastElem = status.elemRead && (status.elementCounter == '0);
    blockEnd = lastElem && (status.frameCount == '0);
    nxt_irq  = 1'b0;
    if (cfg.channelInterruptEnable) begin
      if (cfg.autobufferMode) begin
        nxt_irq = blockEnd || (cfg.halfInterruptMode && status.halfBuffer);
      end else if (cfg.halfInterruptMode) begin
        nxt_irq = lastElem;
      end else begin
        nxt_irq = blockEnd;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      syncEvent_ff  <= 1'b0;
      channelIrq_ff <= 1'b0;
    end else begin
      syncEvent_ff  <= nxt_sync;
      channelIrq_ff <= nxt_irq;
    end
  end

  assign syncEvent  = syncEvent_ff;
  assign channelIrq = channelIrq_ff;

endmodule : dma_channel_event

// file: rtl/dma_sync_irq_route.sv
/*
  Top: six channel event units and CPU interrupt line routing.
  Assumes peripheral events and counter status are synchronous single-cycle pulses.
*/
`timescale 1ns/100ps
module dma_sync_irq_route #(
  parameter int NUM_CH = dma_event_pkg::NUM_CHANNELS
) (
  // Clock and reset
  input  wire logic                                           clk,
  input  wire logic                                           arst_n,
  // Per-channel configuration and transfer status
  input  wire dma_event_pkg::chan_cfg_type    [NUM_CH-1:0]    chanCfg,
  input  wire dma_event_pkg::xfer_status_type [NUM_CH-1:0]    chanStatus,
  // Shared sources
  input  wire dma_event_pkg::sync_src_type                    syncSrc,
  input  wire dma_event_pkg::port_irq_type                    portIrq,
  input  wire logic [dma_event_pkg::ROUTE_WIDTH-1:0]          interruptRoutingSelect,
  // Outputs
  output logic [NUM_CH-1:0]                                   chanSync,
  output logic [NUM_CH-1:0]                                   chanIrq,
  output logic [dma_event_pkg::CPU_IRQ_WIDTH-1:0]             cpuIrq
);

  // ----------------------------------------------------------------------
  // Channel units
  // ----------------------------------------------------------------------
  logic [NUM_CH-1:0] chanIrqRaw;

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
    dma_channel_event u_chan (
      .clk        (clk),
      .arst_n     (arst_n),
      .cfg        (chanCfg[ch]),
      .syncSrc    (syncSrc),
      .status     (chanStatus[ch]),
      .syncEvent  (chanSync[ch]),
      .channelIrq (chanIrqRaw[ch])
    );
  end

  assign chanIrq = chanIrqRaw;

  // ----------------------------------------------------------------------
  // Routing state
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    RT_PORTS = 3'b001,
    RT_HALF  = 3'b010,
    RT_DMA   = 3'b100
  } route_type;

  route_type route_ff;
  route_type nxt_route;
  logic [dma_event_pkg::CPU_IRQ_WIDTH-1:0] cpuIrq_ff;
  logic [dma_event_pkg::CPU_IRQ_WIDTH-1:0] nxt_cpuIrq;

  always_comb begin
    case (interruptRoutingSelect)
      dma_event_pkg::ROUTE_HALF: nxt_route = RT_HALF;
      dma_event_pkg::ROUTE_DMA:  nxt_route = RT_DMA;
      default:                   nxt_route = RT_PORTS;
    endcase
  end

  always_comb begin
    nxt_cpuIrq = '0;
    case (route_ff)
      RT_HALF: begin
        nxt_cpuIrq[dma_event_pkg::LINE_A] = portIrq.port2ReceiveIrq;
        nxt_cpuIrq[dma_event_pkg::LINE_B] = portIrq.port2TransmitIrq;
        nxt_cpuIrq[dma_event_pkg::LINE_C] = chanIrqRaw[2];
        nxt_cpuIrq[dma_event_pkg::LINE_D] = chanIrqRaw[3];
      end
      RT_DMA: begin
        nxt_cpuIrq[dma_event_pkg::LINE_A] = chanIrqRaw[0];
        nxt_cpuIrq[dma_event_pkg::LINE_B] = chanIrqRaw[1];
        nxt_cpuIrq[dma_event_pkg::LINE_C] = chanIrqRaw[2];
        nxt_cpuIrq[dma_event_pkg::LINE_D] = chanIrqRaw[3];
      end
      default: begin
        nxt_cpuIrq[dma_event_pkg::LINE_A] = portIrq.port2ReceiveIrq;
        nxt_cpuIrq[dma_event_pkg::LINE_B] = portIrq.port2TransmitIrq;
        nxt_cpuIrq[dma_event_pkg::LINE_C] = portIrq.port1ReceiveIrq;
        nxt_cpuIrq[dma_event_pkg::LINE_D] = portIrq.port1TransmitIrq;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      route_ff  <= RT_PORTS;
      cpuIrq_ff <= '0;
    end else begin
      route_ff  <= nxt_route;
      cpuIrq_ff <= nxt_cpuIrq;
    end
  end

  assign cpuIrq = cpuIrq_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_reset_route;
    @(posedge clk) disable iff (!arst_n)
      (route_ff == RT_PORTS) |=> cpuIrq[dma_event_pkg::LINE_C] ==
        $past(portIrq.port1ReceiveIrq);
  endproperty
  a_reset_route: assert property (p_reset_route) else $error("line 10 not port 1 rx");

  property p_port_tx_route;
    @(posedge clk) disable iff (!arst_n)
      (route_ff == RT_PORTS) |=> cpuIrq[dma_event_pkg::LINE_D] ==
        $past(portIrq.port1TransmitIrq);
  endproperty
  a_port_tx_route: assert property (p_port_tx_route) else $error("line 11 wrong");

  property p_other_lines;
    @(posedge clk) disable iff (!arst_n)
      (cpuIrq[dma_event_pkg::LINE_A-1:0] == '0) &&
      (cpuIrq[dma_event_pkg::LINE_C-1:dma_event_pkg::LINE_B+1] == '0) &&
      (cpuIrq[dma_event_pkg::CPU_IRQ_WIDTH-1:dma_event_pkg::LINE_D+1] == '0);
  endproperty
  a_other_lines: assert property (p_other_lines) else $error("unrouted line active");

  property p_half_route;
    @(posedge clk) disable iff (!arst_n)
      (route_ff == RT_HALF) |=> (cpuIrq[dma_event_pkg::LINE_D] == $past(chanIrqRaw[3]))
        && (cpuIrq[dma_event_pkg::LINE_A] == $past(portIrq.port2ReceiveIrq));
  endproperty
  a_half_route: assert property (p_half_route) else $error("half routing wrong");

  property p_half_route_bc;
    @(posedge clk) disable iff (!arst_n)
      (route_ff == RT_HALF) |=> (cpuIrq[dma_event_pkg::LINE_C] == $past(chanIrqRaw[2]))
        && (cpuIrq[dma_event_pkg::LINE_B] == $past(portIrq.port2TransmitIrq));
  endproperty
  a_half_route_bc: assert property (p_half_route_bc) else $error("half routing b/c wrong");

  property p_dma_route;
    @(posedge clk) disable iff (!arst_n)
      (route_ff == RT_DMA) |=> (cpuIrq[dma_event_pkg::LINE_A] == $past(chanIrqRaw[0]))
        && (cpuIrq[dma_event_pkg::LINE_B] == $past(chanIrqRaw[1]));
  endproperty
  a_dma_route: assert property (p_dma_route) else $error("dma routing wrong");

  property p_dma_route_cd;
    @(posedge clk) disable iff (!arst_n)
      (route_ff == RT_DMA) |=> (cpuIrq[dma_event_pkg::LINE_C] == $past(chanIrqRaw[2]))
        && (cpuIrq[dma_event_pkg::LINE_D] == $past(chanIrqRaw[3]));
  endproperty
  a_dma_route_cd: assert property (p_dma_route_cd) else $error("dma routing c/d wrong");

  property p_reserved_route;
    @(posedge clk) disable iff (!arst_n)
      (interruptRoutingSelect == 2'h3) |=> (route_ff == RT_PORTS);
  endproperty
  a_reserved_route: assert property (p_reserved_route) else $error("reserved routing");

  property p_route_follows;
    @(posedge clk) disable iff (!arst_n)
      (interruptRoutingSelect == dma_event_pkg::ROUTE_DMA) |=> (route_ff == RT_DMA);
  endproperty
  a_route_follows: assert property (p_route_follows) else $error("routing not taken");

  property p_no_irq_disabled;
    @(posedge clk) disable iff (!arst_n)
      !chanCfg[4].channelInterruptEnable ##1 !chanCfg[4].channelInterruptEnable
        |-> !chanIrqRaw[4];
  endproperty
  a_no_irq_disabled: assert property (p_no_irq_disabled) else $error("irq while disabled");

  property p_block_irq;
    @(posedge clk) disable iff (!arst_n)
      (chanCfg[0].channelInterruptEnable && !chanCfg[0].autobufferMode &&
       chanStatus[0].elemRead && chanStatus[0].elementCounter == '0 &&
       chanStatus[0].frameCount == '0) |=> chanIrqRaw[0];
  endproperty
  a_block_irq: assert property (p_block_irq) else $error("block end irq missing");

  property p_frame_irq;
    @(posedge clk) disable iff (!arst_n)
      (chanCfg[4].channelInterruptEnable && !chanCfg[4].autobufferMode &&
       chanCfg[4].halfInterruptMode && chanStatus[4].elemRead &&
       chanStatus[4].elementCounter == '0) |=> chanIrqRaw[4];
  endproperty
  a_frame_irq: assert property (p_frame_irq) else $error("frame end irq missing");

  property p_half_irq;
    @(posedge clk) disable iff (!arst_n)
      (chanCfg[4].channelInterruptEnable && chanCfg[4].autobufferMode &&
       chanCfg[4].halfInterruptMode && chanStatus[4].halfBuffer) |=> chanIrqRaw[4];
  endproperty
  a_half_irq: assert property (p_half_irq) else $error("half buffer irq missing");

  property p_unsync;
    @(posedge clk) disable iff (!arst_n)
      (chanCfg[0].syncEventSelect == dma_event_pkg::SYNC_NONE) |=> chanSync[0];
  endproperty
  a_unsync: assert property (p_unsync) else $error("unsynced channel stalled");

  property p_timer_sync;
    @(posedge clk) disable iff (!arst_n)
      (chanCfg[0].syncEventSelect == dma_event_pkg::SYNC_TIMER) |=>
        (chanSync[0] == $past(syncSrc.timer));
  endproperty
  a_timer_sync: assert property (p_timer_sync) else $error("timer sync wrong");

  property p_ext3_sync;
    @(posedge clk) disable iff (!arst_n)
      (chanCfg[0].syncEventSelect == dma_event_pkg::SYNC_EXT3) |=>
        (chanSync[0] == $past(syncSrc.ext3));
  endproperty
  a_ext3_sync: assert property (p_ext3_sync) else $error("external 3 sync wrong");

  property p_p2rx_sync;
    @(posedge clk) disable iff (!arst_n)
      (chanCfg[0].syncEventSelect == dma_event_pkg::SYNC_P2_RX) |=>
        (chanSync[0] == $past(syncSrc.p2Rx));
  endproperty
  a_p2rx_sync: assert property (p_p2rx_sync) else $error("port 2 rx sync wrong");

  property p_reserved_sync;
    @(posedge clk) disable iff (!arst_n)
      (chanCfg[0].syncEventSelect == 4'hf) |=> !chanSync[0];
  endproperty
  a_reserved_sync: assert property (p_reserved_sync) else $error("reserved sync fired");

  c_dma_route:  cover property (@(posedge clk) disable iff (!arst_n)
    route_ff == RT_DMA ##1 cpuIrq[dma_event_pkg::LINE_A]);
  c_half_route: cover property (@(posedge clk) disable iff (!arst_n)
    route_ff == RT_HALF ##1 cpuIrq[dma_event_pkg::LINE_D]);
  c_chan_irq:   cover property (@(posedge clk) disable iff (!arst_n) chanIrqRaw[5]);
  c_rsv_route:  cover property (@(posedge clk) disable iff (!arst_n)
    interruptRoutingSelect == 2'h3 ##1 cpuIrq[dma_event_pkg::LINE_C]);

endmodule : dma_sync_irq_route

// file: test/irq_partner_model.sv
/*
  Partner model: peripheral event sources and CPU interrupt flag capture.
  Assumes the bench calls its tasks just after a rising clock edge.
*/
`timescale 1ns/100ps
module irq_partner_model (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  // Routed CPU interrupt lines
  input  wire logic [15:0]            cpuIrq,
  // Event and interrupt sources
  output dma_event_pkg::sync_src_type syncSrc,
  output dma_event_pkg::port_irq_type portIrq
);
  logic [15:0] flags_ff;

  initial begin
    syncSrc = '0;
    portIrq = '0;
  end

  // ----------------------------------------
  // Flag register latches routed lines
  // ----------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_ff <= 16'h0000;
    end else begin
      flags_ff <= flags_ff | cpuIrq;
    end
  end

  // One-cycle event, index 0 is port 0 receive
  task automatic pulseSync(input int idx);
    syncSrc = dma_event_pkg::sync_src_type'(8'h80 >> idx);
    @(posedge clk);
    #1;
    syncSrc = '0;
  endtask : pulseSync

  task automatic drivePort(input logic [3:0] pat);
    portIrq = dma_event_pkg::port_irq_type'(pat);
  endtask : drivePort
endmodule : irq_partner_model

// file: test/testbench.sv
/*
  Self-checking bench for the DMA sync and interrupt routing top.
  Assumes the partner model file and the event package are compiled first.
*/
`timescale 1ns/100ps
module testbench;
  localparam int NCH = dma_event_pkg::NUM_CHANNELS;
  logic                                 clk;
  logic                                 arst_n;
  dma_event_pkg::chan_cfg_type    [NCH-1:0] chanCfg;
  dma_event_pkg::xfer_status_type [NCH-1:0] chanStatus;
  dma_event_pkg::sync_src_type          syncSrc;
  dma_event_pkg::port_irq_type          portIrq;
  logic [1:0]                           interruptRoutingSelect;
  logic [NCH-1:0]                       chanSync;
  logic [NCH-1:0]                       chanIrq;
  logic [15:0]                          cpuIrq;
  int                                   failCount;
  int                                   checks;

  always #4 clk = ~clk;

  dma_sync_irq_route #(.NUM_CH(NCH)) dut (
    .clk(clk), .arst_n(arst_n), .chanCfg(chanCfg), .chanStatus(chanStatus),
    .syncSrc(syncSrc), .portIrq(portIrq), .interruptRoutingSelect(interruptRoutingSelect),
    .chanSync(chanSync), .chanIrq(chanIrq), .cpuIrq(cpuIrq)
  );

  irq_partner_model partner (
    .clk(clk), .arst_n(arst_n), .cpuIrq(cpuIrq), .syncSrc(syncSrc), .portIrq(portIrq)
  );

  // ----------------------------------------
  // Compare, expectation and access tasks
  // ----------------------------------------
  task automatic checkChan(input logic [NCH-1:0] got, input logic [NCH-1:0] exp);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : checkChan

  task automatic checkCpu(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : checkCpu

  task automatic summarize;
    $display("Counts: checks=%0d mismatches=%0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  function automatic logic syncExp(input int c, input int s);
    if (c == 0) return 1'b1;
    if (c >= 1 && c <= 6) return (s == c - 1);
    if (c == 13) return (s == 6);
    if (c == 14) return (s == 7);
    return 1'b0;
  endfunction : syncExp

  function automatic logic [15:0] cpuExp(input int r, input logic [3:0] p,
                                         input logic [3:0] ch);
    logic [15:0] e;
    e = 16'h0000;
    e[6]  = (r == 2) ? ch[0] : p[3];
    e[7]  = (r == 2) ? ch[1] : p[2];
    e[10] = (r == 1 || r == 2) ? ch[2] : p[1];
    e[11] = (r == 1 || r == 2) ? ch[3] : p[0];
    return e;
  endfunction : cpuExp

  // One transfer status pulse on a channel
  task automatic xfer(input int ch, input logic rd, input logic hb,
                      input logic [15:0] elem, input logic [7:0] frame);
    chanStatus[ch] = '{rd, hb, elem, frame};
    @(posedge clk);
    #1;
    chanStatus[ch].elemRead = 1'b0;
    chanStatus[ch].halfBuffer = 1'b0;
  endtask : xfer

  // Channel 4 with {enable, half mode, autobuffer}
  task automatic modeCase(input logic [2:0] eha, input logic rd, input logic hb,
                          input logic [15:0] elem, input logic [7:0] frame, input logic exp);
    chanCfg[4] = '{eha[2], eha[1], eha[0], 4'h0};
    xfer(4, rd, hb, elem, frame);
    checkChan(chanIrq, {1'b0, exp, 4'h0});
    @(posedge clk);
    #1;
    checkChan(chanIrq, 6'h00);
  endtask : modeCase

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    chanCfg = '0;
    chanStatus = '0;
    interruptRoutingSelect = 2'h0;
    failCount = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    #1;
    checkChan(chanSync, 6'h00);
    arst_n = 1'b1;
    @(posedge clk);
    #1;
    checkChan(chanSync, 6'h3f);
    checkCpu(cpuIrq, 16'h0000);
    $display("test reset done");
    for (int c = 0; c < 16; c++) begin
      chanCfg[0].syncEventSelect = c[3:0];
      for (int s = 0; s < 8; s++) begin
        partner.pulseSync(s);
        checkChan({5'h00, chanSync[0]}, {5'h00, syncExp(c, s)});
        // Let an edge pass before the next pulse
        @(posedge clk);
        #1;
      end
    end
    chanCfg[0].syncEventSelect = 4'h0;
    $display("test sync done");
    modeCase(3'h3, 1'b1, 1'b1, 16'h0000, 8'h00, 1'b0);
    modeCase(3'h2, 1'b1, 1'b0, 16'h0000, 8'h00, 1'b0);
    modeCase(3'h5, 1'b0, 1'b1, 16'h0005, 8'h00, 1'b0);
    modeCase(3'h7, 1'b0, 1'b1, 16'h0005, 8'h02, 1'b1);
    modeCase(3'h5, 1'b1, 1'b0, 16'h0000, 8'h00, 1'b1);
    modeCase(3'h5, 1'b1, 1'b0, 16'h0003, 8'h00, 1'b0);
    modeCase(3'h7, 1'b1, 1'b0, 16'h0000, 8'h00, 1'b1);
    modeCase(3'h7, 1'b1, 1'b0, 16'h0000, 8'h02, 1'b0);
    modeCase(3'h4, 1'b1, 1'b0, 16'h0000, 8'h03, 1'b0);
    modeCase(3'h4, 1'b1, 1'b0, 16'h0001, 8'h00, 1'b0);
    modeCase(3'h4, 1'b1, 1'b0, 16'h0000, 8'h00, 1'b1);
    modeCase(3'h6, 1'b1, 1'b0, 16'h0000, 8'h03, 1'b1);
    modeCase(3'h6, 1'b1, 1'b0, 16'h0000, 8'h00, 1'b1);
    modeCase(3'h6, 1'b1, 1'b0, 16'h0001, 8'h00, 1'b0);
    modeCase(3'h6, 1'b0, 1'b1, 16'h0007, 8'h00, 1'b0);
    $display("test modes done");
    for (int ch = 0; ch < NCH; ch++) begin
      chanCfg[ch] = '{1'b1, 1'b0, 1'b0, 4'h0};
    end
    for (int ch = 0; ch < NCH; ch++) begin
      xfer(ch, 1'b1, 1'b0, 16'h0000, 8'h00);
      checkChan(chanIrq, 6'h01 << ch);
    end
    $display("test channels done");
    for (int r = 0; r < 4; r++) begin
      interruptRoutingSelect = r[1:0];
      repeat (3) @(posedge clk);
      #1;
      for (int b = 0; b < 4; b++) begin
        partner.drivePort(4'h8 >> b);
        @(posedge clk);
        #1;
        checkCpu(cpuIrq, cpuExp(r, 4'h8 >> b, 4'h0));
        partner.drivePort(4'h0);
        xfer(b, 1'b1, 1'b0, 16'h0000, 8'h00);
        @(posedge clk);
        #1;
        checkCpu(cpuIrq, cpuExp(r, 4'h0, 4'h1 << b));
      end
    end
    checkCpu(partner.flags_ff, 16'h0cc0);
    $display("test routing done");
    // Mid-run reset with live port sources and channel routing selected
    interruptRoutingSelect = 2'h2;
    partner.drivePort(4'hf);
    @(posedge clk);
    #1;
    arst_n = 1'b0;
    #1;
    checkCpu(cpuIrq, 16'h0000);
    checkChan(chanSync, 6'h00);
    @(posedge clk);
    #1;
    arst_n = 1'b1;
    @(posedge clk);
    #1;
    checkCpu(cpuIrq, 16'h0cc0);
    checkChan(chanSync, 6'h3f);
    @(posedge clk);
    #1;
    checkCpu(cpuIrq, 16'h0000);
    partner.drivePort(4'h0);
    $display("test midreset done");
    summarize();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge clk);
    failCount++;
    summarize();
  end
endmodule : testbench
